// file: logic/aos_in_sync.sv
// Three-stage input synchroniser with agreement filter
`default_nettype none
module aos_in_sync (
	input  wire logic i_sys_clk,
	input  wire logic i_rstn,
	input  wire logic i_async,
	output logic      o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Chain; first stage feeds only the second
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level moves only when stages two and three agree
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_level <= 1'b0;
		end else if (s2_q == s3_q) begin
			o_level <= s3_q;
		end
	end
endmodule : aos_in_sync
`default_nettype wire

// file: logic/aos_sequencer.sv
// Output sequencer and input activation monitor for an addressable loop device
`default_nettype none
// Behaviour
// - Mode 1: latch on until reset/off
// - Mode 2: delay, then latch until reset
// - Modes 3,4: inverted modes 1,2; relay idle energised
// - Inverted open collector: supply idle, zero active
// - Mode 5: single pulse, self clears
// - Mode 6: delay, one pulse per activation
// - Mode 7: pulse train until reset/off
// - Mode 8: delay, then train until reset
// - Level 1: low input reports activation
// - Level 2: high input reports activation
module aos_sequencer
	import aos_pkg::*;
#(
	parameter int TICK_CYCLES = AOS_TICK_CYCLES,
	parameter int TIME_W      = AOS_TIME_W
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_rstn,
	input  wire logic [3:0]        i_out_mode,
	input  wire logic [TIME_W-1:0] i_delay_ticks,
	input  wire logic [TIME_W-1:0] i_width_ticks,
	input  wire logic              i_activate,
	input  wire logic              i_panel_reset,
	input  wire logic              i_switch_off,
	input  wire logic [1:0]        i_in_level,
	input  wire logic              i_sense_pin,
	output logic                   o_relay_on,
	output logic                   o_oc_supply,
	output logic                   o_active,
	output logic                   o_input_report,
	output logic                   o_input_state
);
	// Divider width, sized to hold the cycle count of one tick period
	localparam int TDIV_W = $clog2(TICK_CYCLES + 1);

	aos_state_type     state_q;
	logic [TDIV_W-1:0] div_q;
	logic              tick;
	logic [TIME_W-1:0] tcnt_q;
	logic              sense_lvl;
	logic              sense_act;
	logic              sense_act_q;
	logic [2:0]        settle_q;
	logic              sense_ok;
	logic              stop;
	logic              active_d;

	// True for delayed variants (2,4,6,8)
	function automatic logic aos_has_delay(input logic [3:0] m);
		return (m == AOS_MODE_DLY_LATCH) || (m == AOS_MODE_DLY_INV) ||
			(m == AOS_MODE_DLY_PULSE) || (m == AOS_MODE_DLY_TRAIN);
	endfunction : aos_has_delay

	// True for inverted variants (3,4)
	function automatic logic aos_is_inv(input logic [3:0] m);
		return (m == AOS_MODE_INV) || (m == AOS_MODE_DLY_INV);
	endfunction : aos_is_inv

	// State entered once any delay is over
	function automatic aos_state_type aos_run_state(input logic [3:0] m);
		if ((m == AOS_MODE_PULSE) || (m == AOS_MODE_DLY_PULSE) ||
			(m == AOS_MODE_TRAIN) || (m == AOS_MODE_DLY_TRAIN)) begin
			return AOS_PULSE_HI;
		end
		return AOS_ON;
	endfunction : aos_run_state

	// Reset command or switch-off ends every mode
	assign stop = i_panel_reset || i_switch_off;

	// Sense input synchronised and filtered
	aos_in_sync u_sense_sync (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_async   (i_sense_pin),
		.o_level   (sense_lvl)
	);

	// Synchroniser stages reset low, so an idle-high pin would look like a
	// falling input right after reset; hold the sense off until refilled
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			settle_q <= 3'h0;
		end else if (settle_q != AOS_SETTLE_CNT) begin
			settle_q <= settle_q + 3'h1;
		end
	end
	assign sense_ok = (settle_q == AOS_SETTLE_CNT);

	// level 1 active low, level 2 active high; other codes never report
	always_comb begin
		if (!sense_ok) begin
			sense_act = 1'b0;
		end else if (i_in_level == AOS_LVL_LOW) begin
			sense_act = !sense_lvl;
		end else if (i_in_level == AOS_LVL_HIGH) begin
			sense_act = sense_lvl;
		end else begin
			sense_act = 1'b0;
		end
	end

	// report pulse on the idle-to-active edge
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sense_act_q    <= 1'b0;
			o_input_report <= 1'b0;
			o_input_state  <= 1'b0;
		end else begin
			sense_act_q    <= sense_act;
			o_input_report <= sense_act && !sense_act_q;
			o_input_state  <= sense_act;
		end
	end

	// tick prescaler restarts with each new activation
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_q <= '0;
		end else if (stop || (i_activate && state_q == AOS_IDLE) || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + TDIV_W'(1);
		end
	end
	assign tick = (div_q == TDIV_W'(TICK_CYCLES - 1));

	// Sequencer; tick counter shared by delay and width
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= AOS_IDLE;
			tcnt_q  <= '0;
		end else if (stop) begin
			state_q <= AOS_IDLE;
			tcnt_q  <= '0;
		end else begin
			case (state_q)
				AOS_IDLE: begin
					tcnt_q <= '0;
					if (i_activate) begin
						if (aos_has_delay(i_out_mode) && i_delay_ticks != '0) begin
							state_q <= AOS_DELAY;
						end else begin
							state_q <= aos_run_state(i_out_mode);
						end
					end
				end
				AOS_DELAY: begin
					if (tick) begin
						if (tcnt_q + TIME_W'(1) >= i_delay_ticks) begin
							tcnt_q  <= '0;
							state_q <= aos_run_state(i_out_mode);
						end else begin
							tcnt_q <= tcnt_q + TIME_W'(1);
						end
					end
				end
				AOS_ON: begin
					tcnt_q <= '0;
				end
				AOS_PULSE_HI: begin
					if (tick) begin
						if (tcnt_q + TIME_W'(1) >= i_width_ticks) begin
							tcnt_q <= '0;
							if (i_out_mode == AOS_MODE_PULSE ||
								i_out_mode == AOS_MODE_DLY_PULSE) begin
								state_q <= AOS_DONE;
							end else begin
								state_q <= AOS_PULSE_LO;
							end
						end else begin
							tcnt_q <= tcnt_q + TIME_W'(1);
						end
					end
				end
				AOS_PULSE_LO: begin
					if (tick) begin
						if (tcnt_q + TIME_W'(1) >= i_width_ticks) begin
							tcnt_q  <= '0;
							state_q <= AOS_PULSE_HI;
						end else begin
							tcnt_q <= tcnt_q + TIME_W'(1);
						end
					end
				end
				AOS_DONE: begin
					// wait for activation to drop, no refire
					tcnt_q <= '0;
					if (!i_activate) begin
						state_q <= AOS_IDLE;
					end
				end
				default: begin
					state_q <= AOS_IDLE;
					tcnt_q  <= '0;
				end
			endcase
		end
	end

	// Logical activity of the output
	assign active_d = !stop && ((state_q == AOS_ON) || (state_q == AOS_PULSE_HI));

	// open collector supplies idle in inverted modes
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_active    <= AOS_RST_OUT;
			o_relay_on  <= AOS_RST_OUT;
			o_oc_supply <= AOS_RST_OUT;
		end else begin
			o_active    <= active_d;
			o_relay_on  <= aos_is_inv(i_out_mode) ? !active_d : active_d;
			o_oc_supply <= aos_is_inv(i_out_mode) ? !active_d : active_d;
		end
	end
endmodule : aos_sequencer
`default_nettype wire

// file: shared/aos_pkg.sv
// Package of modes, levels and timing constants for the output sequencer
`default_nettype none
package aos_pkg;
	// Output modes as programmed (1..8)
	localparam logic [3:0] AOS_MODE_LATCH       = 4'h1;
	localparam logic [3:0] AOS_MODE_DLY_LATCH   = 4'h2;
	localparam logic [3:0] AOS_MODE_INV         = 4'h3;
	localparam logic [3:0] AOS_MODE_DLY_INV     = 4'h4;
	localparam logic [3:0] AOS_MODE_PULSE       = 4'h5;
	localparam logic [3:0] AOS_MODE_DLY_PULSE   = 4'h6;
	localparam logic [3:0] AOS_MODE_TRAIN       = 4'h7;
	localparam logic [3:0] AOS_MODE_DLY_TRAIN   = 4'h8;
	// Input activation levels
	localparam logic [1:0] AOS_LVL_LOW          = 2'h1;
	localparam logic [1:0] AOS_LVL_HIGH         = 2'h2;
	// Tick timebase: 1 ms at 50 MHz
	localparam int         AOS_CLK_HZ           = 50000000;
	localparam int         AOS_TICK_US          = 1000;
	localparam int         AOS_TICK_CYCLES      = AOS_CLK_HZ / 1000000 * AOS_TICK_US;
	// Widths of the programmable counts
	localparam int         AOS_TIME_W           = 16;
	// Reset values
	localparam logic       AOS_RST_OUT          = 1'b0;
	// Edges after reset before the sense synchroniser output is trusted
	localparam logic [2:0] AOS_SETTLE_CNT       = 3'h5;
	// Sequencer states
	typedef enum logic [2:0] {
		AOS_IDLE,
		AOS_DELAY,
		AOS_ON,
		AOS_PULSE_HI,
		AOS_PULSE_LO,
		AOS_DONE
	} aos_state_type;
endpackage : aos_pkg
`default_nettype wire

// file: sim/aos_panel_model.sv
// Panel model: turns commands and input reports into activation
`default_nettype none
module aos_panel_model (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_cmd,
	input wire logic i_assign,
	input wire logic i_report,
	input wire logic i_clear,
	output logic     o_activate
);
	// only assigned outputs follow a report
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			o_activate <= 1'b0;
		else if (i_clear)
			o_activate <= 1'b0;
		else
			o_activate <= i_cmd | (i_assign & (i_report | o_activate));
	end
endmodule : aos_panel_model
`default_nettype wire

// file: sim/aos_seq_chk_assertions.sv
// Port-level assertion checker for the output sequencer
`default_nettype none
module aos_seq_chk
	import aos_pkg::*;
#(
	parameter int TICK_CYCLES = AOS_TICK_CYCLES,
	parameter int TIME_W      = AOS_TIME_W
) (
	input wire logic              i_sys_clk,
	input wire logic              i_rstn,
	input wire logic [3:0]        i_out_mode,
	input wire logic [TIME_W-1:0] i_delay_ticks,
	input wire logic [TIME_W-1:0] i_width_ticks,
	input wire logic              i_activate,
	input wire logic              i_panel_reset,
	input wire logic              i_switch_off,
	input wire logic [1:0]        i_in_level,
	input wire logic              i_sense_pin,
	input wire logic              o_relay_on,
	input wire logic              o_oc_supply,
	input wire logic              o_active,
	input wire logic              o_input_report,
	input wire logic              o_input_state
);
	// Single domain, reset masks everything
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);
	wire clr  = i_panel_reset | i_switch_off;
	wire fast = (TICK_CYCLES == 4) && (i_width_ticks == 2);
	// Latch, clear, polarity and timing relations
	latch_hold_a: assert property (i_out_mode == AOS_MODE_LATCH && o_active && !clr |=> o_active)
		else $error("latched output dropped");
	clear_drop_a: assert property (clr |=> !o_active)
		else $error("output kept after clear");
	oc_track_a: assert property (o_oc_supply == o_relay_on)
		else $error("open collector differs from relay");
	inv_relay_a: assert property ($past(i_rstn) && $past(i_out_mode) == AOS_MODE_INV &&
		$stable(i_out_mode) |-> o_relay_on != o_active)
		else $error("inverted relay polarity wrong");
	dly_latch_a: assert property ($rose(i_activate) && !o_active && !clr && fast && i_delay_ticks == 2
		&& i_out_mode == AOS_MODE_DLY_LATCH ##0 (!clr)[*8] ##1 (!clr)[*2] |->
		!o_active && !$past(o_active, 8) ##1 o_active)
		else $error("delayed latch timing wrong");
	pulse_width_a: assert property ($rose(o_active) && i_out_mode == AOS_MODE_PULSE && fast |->
		o_active[*8] ##1 !o_active)
		else $error("pulse width wrong");
	train_gap_a: assert property ($fell(o_active) && i_out_mode == AOS_MODE_TRAIN && fast &&
		!$past(clr) |-> (!o_active)[*8] ##1 o_active)
		else $error("train gap wrong");
	in_low_a: assert property ((i_in_level == AOS_LVL_LOW && !i_sense_pin)[*7] |-> o_input_state)
		else $error("low input not seen active");
	report_pulse_a: assert property ($rose(o_input_state) |-> o_input_report ##1 !o_input_report)
		else $error("report pulse wrong");
endmodule : aos_seq_chk
bind aos_sequencer aos_seq_chk #(.TICK_CYCLES(TICK_CYCLES), .TIME_W(TIME_W)) chk_u (.*);
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the output sequencer
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import aos_pkg::*;
	typedef struct {logic [3:0] m; int lat; int hi; logic inv;} aos_row_type;
	logic        i_sys_clk = 1'b0, i_rstn = 1'b0, cmd = 1'b0, asg = 1'b0, rst = 1'b0, off = 1'b0;
	logic        pin = 1'b1, act, relay, oc, actv, rep, st;
	logic [3:0]  mode = 4'h1;
	logic [1:0]  lvl = 2'h1;
	logic [15:0] dly = 16'h0002, wid = 16'h0002;
	int          err_total = 0, checks_done = 0, n;
	// one row per output mode: edges to activate, edges high (0 latches), relay inverted
	aos_row_type rows [8] = '{'{AOS_MODE_LATCH, 2, 0, 0}, '{AOS_MODE_DLY_LATCH, 10, 0, 0},
		'{AOS_MODE_INV, 2, 0, 1}, '{AOS_MODE_DLY_INV, 10, 0, 1}, '{AOS_MODE_PULSE, 2, 8, 0},
		'{AOS_MODE_DLY_PULSE, 10, 8, 0}, '{AOS_MODE_TRAIN, 2, 8, 0}, '{AOS_MODE_DLY_TRAIN, 10, 8, 0}};
	// Short tick keeps every delay a few cycles
	aos_sequencer #(.TICK_CYCLES(4)) dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_out_mode(mode),
		.i_delay_ticks(dly), .i_width_ticks(wid), .i_activate(act), .i_panel_reset(rst),
		.i_switch_off(off), .i_in_level(lvl), .i_sense_pin(pin), .o_relay_on(relay),
		.o_oc_supply(oc), .o_active(actv), .o_input_report(rep), .o_input_state(st));
	aos_panel_model pnl_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cmd(cmd), .i_assign(asg),
		.i_report(rep), .i_clear(rst | off), .o_activate(act));
	// Clock and watchdog
	initial forever #10 i_sys_clk = ~i_sys_clk;
	initial begin
		#200us;
		err_total++;
		close_out();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	// Edges until the output reaches v; 60 means it never did
	task automatic until_act(input logic v, output int k);
		k = 0;
		while (actv !== v && k < 60) begin
			@(posedge i_sys_clk);
			#1;
			k++;
		end
	endtask : until_act
	// Clear by panel reset or switch-off, then idle polarity
	task automatic clear(input logic use_off, input logic inv);
		@(posedge i_sys_clk);
		rst <= !use_off;
		off <= use_off;
		cmd <= 1'b0;
		@(posedge i_sys_clk);
		rst <= 1'b0;
		off <= 1'b0;
		@(posedge i_sys_clk);
		#1;
		chk(actv, 1'b0);
		chk(relay, inv);
	endtask : clear
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	// Mode table, then abort and input reporting
	initial begin
		repeat (8) @(posedge i_sys_clk);
		chk({relay, oc, actv, rep, st}, 5'h00);
		i_rstn <= 1'b1;
		foreach (rows[r]) begin
			@(posedge i_sys_clk);
			mode <= rows[r].m;
			cmd <= 1'b1;
			@(posedge i_sys_clk);
			#1;
			until_act(1'b1, n);
			chk(n, rows[r].lat);
			chk({relay, oc}, {2{!rows[r].inv}});
			until_act(1'b0, n);
			chk(n, rows[r].hi == 0 ? 60 : rows[r].hi);
			if (rows[r].hi != 0) begin
				until_act(1'b1, n);
				chk(n, rows[r].m >= AOS_MODE_TRAIN ? 8 : 60);
			end
			clear(r % 2, rows[r].inv);
		end
		@(posedge i_sys_clk);
		mode <= AOS_MODE_DLY_LATCH;
		cmd <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		clear(1'b0, 1'b0);
		until_act(1'b1, n);
		chk(n, 60);
		for (int l = 1; l <= 2; l++) begin
			@(posedge i_sys_clk);
			mode <= AOS_MODE_LATCH;
			lvl <= l[1:0];
			pin <= (l == 1);
			asg <= 1'b1;
			repeat (10) @(posedge i_sys_clk);
			#1;
			chk(st, 1'b0);
			@(posedge i_sys_clk);
			pin <= (l != 1);
			n = 0;
			while (rep !== 1'b1 && n < 20) begin
				@(posedge i_sys_clk);
				#1;
				n++;
			end
			chk({rep, st}, 2'h3);
			until_act(1'b1, n);
			chk(n, 3);
			// Low is idle for the next level, so move the pin there now
			pin <= 1'b0;
			asg <= 1'b0;
			clear(1'b1, 1'b0);
			// Let any report from the pin move pass while unassigned
			repeat (8) @(posedge i_sys_clk);
		end
		close_out();
	end
endmodule : tb_top
`default_nettype wire
